// *** verilog/dbgec_top.sv ***
`timescale 1ns/1ps
module dbgec_top #(
  parameter dbgec_pkg::dbgec_ver_t VERSION = dbgec_pkg::VER_NEW
) (
  input wire logic REF_CLK, // 250 MHz clock
  input wire logic RSTN, // Asynchronous reset, active low
  input wire logic ENTRY, // Pulse: core enters halted state
  input wire dbgec_pkg::dbgec_evt_t ENTRY_EVT, // Reasons for the entry
  input wire logic EXIT_REQ, // Pulse: exit halted state
  input wire dbgec_pkg::dbgec_abort_t ABORT, // Abort pulses, discard level
  input wire logic EXEC_EN, // Execute-instruction enable level
  input wire logic SW_SOFTWARE_BREAKPOINT_INSTRUCTION_EXEC, // Pulse: software breakpoint executed
  input wire logic DEBUG_PERMITTED, // Level: debug enabled and allowed
  input wire logic [31:0] SOFTWARE_BREAKPOINT_INSTRUCTION_PC, // Address of the breakpoint
  input wire logic EXT_RD, // Pulse: debugger reads status word
  input wire logic RUN_CTRL_WR, // Pulse: run-control word written
  input wire logic [31:0] RUN_CTRL_DATA, // Run-control write data
  input wire logic XFER_VALID, // Pulse: transfer word offered
  output logic [31:0] STATUS_WORD, // Debug status word
  output logic HALTED, // Halted state level
  output logic XFER_ISSUE, // Pulse: transfer word issued
  output logic IMP_ABORT_TAKE, // Pulse: held abort taken
  output logic DBG_EXC, // Pulse: debug exception
  output logic FAULT_WE, // Pulse: fault registers load
  output logic [4:0] FAULT_STATUS, // Fault status value
  output logic [31:0] FAULT_ADDR // Fault address value
);

  generate
    if (VERSION != dbgec_pkg::VER_OLD && VERSION != dbgec_pkg::VER_MID &&
        VERSION != dbgec_pkg::VER_NEW) begin : g_bad_ver
      $error("dbgec_top: unsupported version");
    end
  endgenerate

  localparam bit IS_OLD = (VERSION == dbgec_pkg::VER_OLD);
  localparam bit IS_MID = (VERSION == dbgec_pkg::VER_MID);
  localparam bit IS_NEW = (VERSION == dbgec_pkg::VER_NEW);

  dbgec_pkg::dbgec_state_t state_q;
  dbgec_pkg::dbgec_state_t state_d;
  logic [3:0] cause_q;
  logic [3:0] cause_d;
  logic prec_q;
  logic prec_d;
  logic imp_q;
  logic imp_d;
  logic pend_q;
  logic pend_d;
  logic [31:0] word_d;

  wire halted = (state_q == dbgec_pkg::ST_HALT);
  wire enter = ENTRY && !halted;
  wire leave = EXIT_REQ && halted;
  wire software_breakpoint_instruction_exc = SW_SOFTWARE_BREAKPOINT_INSTRUCTION_EXEC && !DEBUG_PERMITTED && !halted && !ENTRY;

  always_comb begin
    state_d = state_q;
    unique case (state_q)
      dbgec_pkg::ST_RUN: begin
        if (ENTRY) begin
          state_d = dbgec_pkg::ST_HALT;
        end
      end
      dbgec_pkg::ST_HALT: begin
        if (EXIT_REQ) begin
          state_d = dbgec_pkg::ST_RUN;
        end
      end
    endcase
  end

  // Version-gated event qualifiers; reserved codes never get loaded
  wire os_ok = ENTRY_EVT.os_unlock && IS_NEW;
  wire pw_ok = ENTRY_EVT.prec_watch && IS_NEW;
  wire da_ok = ENTRY_EVT.dside_abort && IS_OLD;
  wire ia_ok = ENTRY_EVT.iside_abort && IS_OLD;

  // Fixed priority; with no reason flagged the entry counts as halt request
  wire [3:0] cause_sel =
    ENTRY_EVT.ext_req ? dbgec_pkg::CAUSE_EXT_REQ :
    ENTRY_EVT.halt_req ? dbgec_pkg::CAUSE_HALT_REQ :
    os_ok ? dbgec_pkg::CAUSE_OS_UNLOCK :
    ENTRY_EVT.vec_catch ? dbgec_pkg::CAUSE_VEC_CATCH :
    ENTRY_EVT.sw_software_breakpoint_instruction ? dbgec_pkg::CAUSE_SW_SOFTWARE_BREAKPOINT_INSTRUCTION :
    ENTRY_EVT.hw_software_breakpoint_instruction ? dbgec_pkg::CAUSE_HW_SOFTWARE_BREAKPOINT_INSTRUCTION :
    pw_ok ? dbgec_pkg::CAUSE_PREC_WATCH :
    ENTRY_EVT.imp_watch ? dbgec_pkg::CAUSE_IMP_WATCH :
    da_ok ? dbgec_pkg::CAUSE_DSIDE_ABORT :
    ia_ok ? dbgec_pkg::CAUSE_ISIDE_ABORT :
    dbgec_pkg::CAUSE_HALT_REQ;

  // Cause moves only on entry or on a breakpoint debug exception
  assign cause_d = enter ? cause_sel :
                   software_breakpoint_instruction_exc ? dbgec_pkg::CAUSE_SW_SOFTWARE_BREAKPOINT_INSTRUCTION :
                   cause_q;

  // Oldest version leaves the flags undefined when not executing, so
  // the simplest form (set only while halted) is kept for all versions
  wire prec_set = halted && ABORT.precise;
  wire imp_any = halted && ABORT.imprecise;
  wire discard = ABORT.discard && !IS_OLD;
  wire imp_set = IS_NEW ? (imp_any && discard) : imp_any;

  // Middle version freezes flags outside halted state, newest too
  wire clr_rd = EXT_RD && (IS_OLD || (IS_MID && halted));
  wire clr_wr = IS_NEW && halted && RUN_CTRL_WR &&
                RUN_CTRL_DATA[dbgec_pkg::RUNCTL_CLR_BIT];
  wire clr = clr_rd || clr_wr;

  // A set in the clearing cycle wins so no abort is lost
  assign prec_d = prec_set || (prec_q && !clr);
  assign imp_d = imp_set || (imp_q && !clr);

  // Undiscarded imprecise abort waits for the exit
  wire hold_set = imp_any && !discard;
  // An abort landing on the exit edge is taken at that exit; none lingers
  assign pend_d = (hold_set || pend_q) && !leave;

  wire flags_vis = !(IS_MID && state_d != dbgec_pkg::ST_HALT);

  always_comb begin
    word_d = dbgec_pkg::WORD_RESET;
    word_d[dbgec_pkg::HALTED_BIT] = (state_d == dbgec_pkg::ST_HALT);
    word_d[dbgec_pkg::CAUSE_HI:dbgec_pkg::CAUSE_LO] = cause_d;
    word_d[dbgec_pkg::PRECISE_BIT] = prec_d && flags_vis;
    word_d[dbgec_pkg::IMPRECISE_BIT] = imp_d && flags_vis;
  end

  // Transfer words are refused once a precise abort is recorded
  wire issue_d = XFER_VALID && halted && !prec_q;

  always_ff @(posedge REF_CLK or negedge RSTN) begin
    if (!RSTN) begin
      state_q <= dbgec_pkg::ST_RUN;
      cause_q <= dbgec_pkg::CAUSE_RESET;
      prec_q <= 1'b0;
      imp_q <= 1'b0;
      pend_q <= 1'b0;
    end else begin
      state_q <= state_d;
      cause_q <= cause_d;
      prec_q <= prec_d;
      imp_q <= imp_d;
      pend_q <= pend_d;
    end
  end

  always_ff @(posedge REF_CLK or negedge RSTN) begin
    if (!RSTN) begin
      STATUS_WORD <= dbgec_pkg::WORD_RESET;
      HALTED <= 1'b0;
      XFER_ISSUE <= 1'b0;
      IMP_ABORT_TAKE <= 1'b0;
    end else begin
      STATUS_WORD <= word_d;
      HALTED <= (state_d == dbgec_pkg::ST_HALT);
      XFER_ISSUE <= issue_d;
      IMP_ABORT_TAKE <= leave && (pend_q || hold_set);
    end
  end

  always_ff @(posedge REF_CLK or negedge RSTN) begin
    if (!RSTN) begin
      DBG_EXC <= 1'b0;
      FAULT_WE <= 1'b0;
      FAULT_STATUS <= dbgec_pkg::FAULT_STATUS_RESET;
      FAULT_ADDR <= dbgec_pkg::ADDR_RESET;
    end else begin
      DBG_EXC <= software_breakpoint_instruction_exc;
      FAULT_WE <= software_breakpoint_instruction_exc;
      if (software_breakpoint_instruction_exc) begin
        FAULT_STATUS <= dbgec_pkg::FAULT_DEBUG_EVENT;
        FAULT_ADDR <= SOFTWARE_BREAKPOINT_INSTRUCTION_PC;
      end
    end
  end

  default clocking cb @(posedge REF_CLK);
  endclocking
  default disable iff (!RSTN);

  cause_on_entry_a: assert property (
    (ENTRY && !HALTED) |=> (STATUS_WORD[5:2] == $past(cause_sel)))
    else $error("cause not loaded on entry");

  cause_hold_a: assert property (
    (!ENTRY && !software_breakpoint_instruction_exc) |=> $stable(STATUS_WORD[5:2]))
    else $error("cause changed without entry");

  ext_req_code_a: assert property (
    (ENTRY && !HALTED && ENTRY_EVT.ext_req) |=>
      (STATUS_WORD[5:2] == 4'h4))
    else $error("external request code wrong");

  halt_req_code_a: assert property (
    (ENTRY && !HALTED && ENTRY_EVT == 10'h000) |=>
      (STATUS_WORD[5:2] == 4'h0))
    else $error("halt request code wrong");

  hw_software_breakpoint_instruction_code_a: assert property (
    (ENTRY && !HALTED && ENTRY_EVT == 10'h100) |=>
      (STATUS_WORD[5:2] == 4'h1))
    else $error("hardware breakpoint code wrong");

  sw_software_breakpoint_instruction_code_a: assert property (
    (ENTRY && !HALTED && ENTRY_EVT == 10'h040) |=>
      (STATUS_WORD[5:2] == 4'h3))
    else $error("software breakpoint code wrong");

  reserved_code_a: assert property (
    IS_OLD || (STATUS_WORD[5:2] != 4'h6 && STATUS_WORD[5:2] != 4'h7))
    else $error("abort code outside oldest version");

  late_code_a: assert property (
    IS_NEW || (STATUS_WORD[5:2] != 4'h8 && STATUS_WORD[5:2] != 4'ha))
    else $error("newest-only code in older version");

  software_breakpoint_instruction_exc_a: assert property (
    (SW_SOFTWARE_BREAKPOINT_INSTRUCTION_EXEC && !DEBUG_PERMITTED && !HALTED && !ENTRY) |=>
      (DBG_EXC && FAULT_WE && STATUS_WORD[5:2] == 4'h3 &&
       FAULT_ADDR == $past(SOFTWARE_BREAKPOINT_INSTRUCTION_PC)))
    else $error("breakpoint exception not raised");

  precise_set_a: assert property (
    (HALTED && ABORT.precise && !(IS_MID && EXIT_REQ)) |=>
      STATUS_WORD[6] ##1 (prec_q || $past(clr)))
    else $error("precise flag not set and kept");

  frozen_a: assert property (
    (!IS_OLD && !HALTED && !ENTRY) |=> ($stable(prec_q) && $stable(imp_q)))
    else $error("flag moved outside halted state");

  read_clear_a: assert property (
    (!IS_NEW && EXT_RD && HALTED && !ABORT.precise && !EXIT_REQ) |=>
      !STATUS_WORD[6])
    else $error("read did not clear flag");

  write_clear_a: assert property (
    (IS_NEW && prec_q && !(HALTED && RUN_CTRL_WR && RUN_CTRL_DATA[2]))
      |=> prec_q)
    else $error("flag cleared without run-control write");

  mid_zero_a: assert property (
    (IS_MID && !HALTED) |-> (STATUS_WORD[7:6] == 2'b00))
    else $error("flag visible outside halted state");

  no_issue_a: assert property (
    (STATUS_WORD[6] && HALTED && !EXIT_REQ) |=> !XFER_ISSUE)
    else $error("transfer issued with precise flag set");

  imp_new_a: assert property (
    (IS_NEW && !imp_q && !(HALTED && ABORT.imprecise && ABORT.discard))
      |=> !imp_q)
    else $error("imprecise flag set without discard");

  held_take_a: assert property (
    (HALTED && ABORT.imprecise && !discard && !EXIT_REQ) ##1
      (EXIT_REQ && HALTED) |=> IMP_ABORT_TAKE)
    else $error("held abort not taken at exit");

  halted_bit_a: assert property (
    (STATUS_WORD[0] == HALTED) and (ENTRY && !HALTED |=> HALTED))
    else $error("halted bit wrong");

  // Remaining entry codes except the abort codes, and the fixed priority
  halt_req_prio_a: assert property (
    (ENTRY && !HALTED && ENTRY_EVT.halt_req && !ENTRY_EVT.ext_req) |=>
      (STATUS_WORD[5:2] == 4'h0))
    else $error("halt request priority wrong");

  imp_watch_code_a: assert property (
    (ENTRY && !HALTED && ENTRY_EVT == 10'h080) |=>
      (STATUS_WORD[5:2] == 4'h2))
    else $error("imprecise watchpoint code wrong");

  vec_catch_code_a: assert property (
    (ENTRY && !HALTED && ENTRY_EVT == 10'h010) |=>
      (STATUS_WORD[5:2] == 4'h5))
    else $error("vector catch code wrong");

  os_unlock_code_a: assert property (
    (IS_NEW && ENTRY && !HALTED && ENTRY_EVT == 10'h002) |=>
      (STATUS_WORD[5:2] == 4'h8))
    else $error("unlock catch code wrong");

  prec_watch_code_a: assert property (
    (IS_NEW && ENTRY && !HALTED && ENTRY_EVT == 10'h001) |=>
      (STATUS_WORD[5:2] == 4'ha))
    else $error("precise watchpoint code wrong");

  // Sticky flags and the held abort
  mid_imp_set_a: assert property (
    (IS_MID && HALTED && ABORT.imprecise && !EXIT_REQ) |=>
      STATUS_WORD[7])
    else $error("imprecise flag not set in middle version");

  write_clears_a: assert property (
    (IS_NEW && HALTED && RUN_CTRL_WR && RUN_CTRL_DATA[2] &&
     !ABORT.precise && !ABORT.imprecise) |=> (STATUS_WORD[7:6] == 2'h0))
    else $error("run-control write did not clear flags");

  imp_read_clear_a: assert property (
    (!IS_NEW && EXT_RD && HALTED && !ABORT.imprecise && !EXIT_REQ) |=>
      !STATUS_WORD[7])
    else $error("read did not clear imprecise flag");

  pend_clear_a: assert property (
    (EXIT_REQ && HALTED) |=> !pend_q)
    else $error("held abort kept after exit");

  take_pulse_a: assert property (
    IMP_ABORT_TAKE |=> !IMP_ABORT_TAKE)
    else $error("held abort taken twice");

  // Exception, transfer and halted state
  no_spurious_exc_a: assert property (
    !(SW_SOFTWARE_BREAKPOINT_INSTRUCTION_EXEC && !DEBUG_PERMITTED && !HALTED && !ENTRY) |=>
      !DBG_EXC)
    else $error("debug exception without cause");

  fault_hold_a: assert property (
    !software_breakpoint_instruction_exc |=>
      ($stable(FAULT_ADDR) && $stable(FAULT_STATUS)))
    else $error("fault registers moved without exception");

  issue_ok_a: assert property (
    (XFER_VALID && HALTED && !prec_q) |=> XFER_ISSUE)
    else $error("transfer word not issued");

  state_hold_a: assert property (
    ((HALTED && !EXIT_REQ) || (!HALTED && !ENTRY)) |=>
      $stable(HALTED))
    else $error("halted state moved without request");

  entry_exit_c: cover property (
    (ENTRY && !HALTED) ##[1:20] (EXIT_REQ && HALTED));
  precise_block_c: cover property (
    (HALTED && ABORT.precise) ##1 XFER_VALID);
  clear_c: cover property (prec_q ##1 clr ##1 !prec_q);
  exc_c: cover property (DBG_EXC);
  abort_take_c: cover property (
    (EXIT_REQ && HALTED) ##1 IMP_ABORT_TAKE);

endmodule

// *** verilog/dbgec_pkg.sv ***
// Contract
// - Cause field bits 5:2, halt request 0000
// - Hardware breakpoint entry loads cause 0001
// - Imprecise watchpoint entry loads cause 0010
// - Software breakpoint entry loads cause 0011
// - External debug request entry loads 0100
// - Vector catch entry loads cause 0101
// - Oldest version only: aborts 0110, 0111
// - Newest version: OS unlock catch 1000
// - Newest version: precise watchpoint 1010
// - Disabled software breakpoint raises debug exception
// - Precise abort when halted sets bit 6
// - Middle/newest: flags frozen outside halted state
// - Older versions: debugger read clears flags
// - Newest: only run-control bit 2 clears
// - Middle: flags read zero outside halted
// - Precise flag set blocks instruction issue
// - Middle: any halted imprecise abort sets bit 7
// - Newest: only discarded imprecise aborts set
// - Undiscarded imprecise abort taken at exit
// - Oldest: flags undefined without execute enable
// - Bit 0 shows halted state
package dbgec_pkg;

  localparam int WORD_W = 32;
  localparam int HALTED_BIT = 0;
  localparam int CAUSE_LO = 2;
  localparam int CAUSE_HI = 5;
  localparam int PRECISE_BIT = 6;
  localparam int IMPRECISE_BIT = 7;
  localparam int RUNCTL_CLR_BIT = 2;
  localparam int FAULT_STATUS_W = 5;

  localparam logic [3:0] CAUSE_HALT_REQ = 4'h0;
  localparam logic [3:0] CAUSE_HW_SOFTWARE_BREAKPOINT_INSTRUCTION = 4'h1;
  localparam logic [3:0] CAUSE_IMP_WATCH = 4'h2;
  localparam logic [3:0] CAUSE_SW_SOFTWARE_BREAKPOINT_INSTRUCTION = 4'h3;
  localparam logic [3:0] CAUSE_EXT_REQ = 4'h4;
  localparam logic [3:0] CAUSE_VEC_CATCH = 4'h5;
  localparam logic [3:0] CAUSE_DSIDE_ABORT = 4'h6;
  localparam logic [3:0] CAUSE_ISIDE_ABORT = 4'h7;
  localparam logic [3:0] CAUSE_OS_UNLOCK = 4'h8;
  localparam logic [3:0] CAUSE_PREC_WATCH = 4'ha;

  localparam logic [3:0] CAUSE_RESET = 4'h0;
  localparam logic [31:0] WORD_RESET = 32'h0000_0000;
  localparam logic [31:0] ADDR_RESET = 32'h0000_0000;
  localparam logic [4:0] FAULT_STATUS_RESET = 5'h00;
  // Fault status code reported for a debug event
  localparam logic [4:0] FAULT_DEBUG_EVENT = 5'h02;

  typedef enum logic [1:0] {
    VER_OLD = 2'b00,
    VER_MID = 2'b01,
    VER_NEW = 2'b10
  } dbgec_ver_t;

  typedef enum logic {
    ST_RUN = 1'b0,
    ST_HALT = 1'b1
  } dbgec_state_t;

  // Reasons for a debug entry, presented with the entry pulse
  typedef struct packed {
    logic halt_req;
    logic hw_software_breakpoint_instruction;
    logic imp_watch;
    logic sw_software_breakpoint_instruction;
    logic ext_req;
    logic vec_catch;
    logic dside_abort;
    logic iside_abort;
    logic os_unlock;
    logic prec_watch;
  } dbgec_evt_t;

  // Aborts raised by instructions issued while halted
  typedef struct packed {
    logic precise;
    logic imprecise;
    logic discard;
  } dbgec_abort_t;

endpackage

// *** test/dbgec_dbg_model.sv ***
`timescale 1ns/1ps
module dbgec_dbg_model (
  input wire logic clk, // Reference clock
  output logic ext_rd, // Status word read pulse
  output logic run_ctrl_wr, // Run-control write pulse
  output logic [31:0] run_ctrl_data, // Run-control write data
  output logic exit_req // Exit request pulse
);
  initial begin
    ext_rd = 1'b0;
    run_ctrl_wr = 1'b0;
    run_ctrl_data = 32'h0000_0000;
    exit_req = 1'b0;
  end
  task automatic read_status;
    @(posedge clk) ext_rd <= 1'b1;
    @(posedge clk) ext_rd <= 1'b0;
  endtask
  task automatic write_run_ctrl(input logic [31:0] d);
    @(posedge clk) begin
      run_ctrl_wr <= 1'b1;
      run_ctrl_data <= d;
    end
    // Data is stale once released, so show its inverse
    @(posedge clk) begin
      run_ctrl_wr <= 1'b0;
      run_ctrl_data <= ~d;
    end
  endtask
  // Exiting with a sticky flag set is undefined, so write run-control bit 2 first; that clears only the newest version
  task automatic leave;
    write_run_ctrl(32'h0000_0004);
    @(posedge clk) exit_req <= 1'b1;
    @(posedge clk) exit_req <= 1'b0;
  endtask
endmodule

// *** test/dbgec_top_tb.sv ***
`timescale 1ns/1ps
module dbgec_top_tb;
  typedef struct packed {
    dbgec_pkg::dbgec_evt_t evt;
    logic [3:0] cause;
  } dbgec_row_t;
  logic ref_clk, rstn, entry, sw_software_breakpoint_instruction_exec, permitted, xfer_valid, t;
  logic ext_rd, run_ctrl_wr, exit_req, halted, xfer_issue, imp_take;
  logic dbg_exc, fault_we;
  logic [31:0] run_ctrl_data, software_breakpoint_instruction_pc, sw, fault_addr, sw_mid;
  logic [4:0] fault_status;
  dbgec_pkg::dbgec_evt_t entry_evt;
  dbgec_pkg::dbgec_abort_t abort;
  int fail_count, samples_checked;
  dbgec_row_t rows[11];
  dbgec_top #(.VERSION(dbgec_pkg::VER_NEW)) DUT (
    .REF_CLK(ref_clk), .RSTN(rstn), .ENTRY(entry), .ENTRY_EVT(entry_evt),
    .EXIT_REQ(exit_req), .ABORT(abort), .EXEC_EN(1'b1),
    .SW_SOFTWARE_BREAKPOINT_INSTRUCTION_EXEC(sw_software_breakpoint_instruction_exec), .DEBUG_PERMITTED(permitted),
    .SOFTWARE_BREAKPOINT_INSTRUCTION_PC(software_breakpoint_instruction_pc), .EXT_RD(ext_rd), .RUN_CTRL_WR(run_ctrl_wr),
    .RUN_CTRL_DATA(run_ctrl_data), .XFER_VALID(xfer_valid),
    .STATUS_WORD(sw), .HALTED(halted), .XFER_ISSUE(xfer_issue),
    .IMP_ABORT_TAKE(imp_take), .DBG_EXC(dbg_exc), .FAULT_WE(fault_we),
    .FAULT_STATUS(fault_status), .FAULT_ADDR(fault_addr));
  // Middle version shares every input; only its status word is watched
  dbgec_top #(.VERSION(dbgec_pkg::VER_MID)) dut_mid (
    .REF_CLK(ref_clk), .RSTN(rstn), .ENTRY(entry), .ENTRY_EVT(entry_evt),
    .EXIT_REQ(exit_req), .ABORT(abort), .EXEC_EN(1'b1),
    .SW_SOFTWARE_BREAKPOINT_INSTRUCTION_EXEC(sw_software_breakpoint_instruction_exec), .DEBUG_PERMITTED(permitted),
    .SOFTWARE_BREAKPOINT_INSTRUCTION_PC(software_breakpoint_instruction_pc), .EXT_RD(ext_rd), .RUN_CTRL_WR(run_ctrl_wr),
    .RUN_CTRL_DATA(run_ctrl_data), .XFER_VALID(xfer_valid),
    .STATUS_WORD(sw_mid), .HALTED(), .XFER_ISSUE(), .IMP_ABORT_TAKE(),
    .DBG_EXC(), .FAULT_WE(), .FAULT_STATUS(), .FAULT_ADDR());
  dbgec_dbg_model dbg (.clk(ref_clk), .ext_rd(ext_rd),
    .run_ctrl_wr(run_ctrl_wr), .run_ctrl_data(run_ctrl_data),
    .exit_req(exit_req));
  initial ref_clk = 1'b0;
  always #2 ref_clk = ~ref_clk;
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      fail_count++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic close_out;
    $display("checked=%0d failed=%0d", samples_checked, fail_count);
    if (fail_count == 0 && samples_checked > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  task automatic settle;
    @(posedge ref_clk);
    #1;
  endtask
  task automatic enter(input dbgec_pkg::dbgec_evt_t e);
    @(posedge ref_clk) begin
      entry <= 1'b1;
      entry_evt <= e;
    end
    @(posedge ref_clk) begin
      entry <= 1'b0;
      entry_evt <= '0;
    end
    #1;
  endtask
  task automatic abt(input dbgec_pkg::dbgec_abort_t a);
    @(posedge ref_clk) abort <= a;
    @(posedge ref_clk) abort <= {2'b00, a.discard};
    #1;
  endtask
  task automatic xfer(input logic exp);
    @(posedge ref_clk) xfer_valid <= 1'b1;
    @(posedge ref_clk) xfer_valid <= 1'b0;
    #1 chk({31'h0, xfer_issue}, {31'h0, exp});
  endtask
  initial begin
    repeat (5000) @(posedge ref_clk);
    fail_count++;
    close_out();
  end
  initial begin
    rstn = 1'b0; entry = 1'b0; entry_evt = '0; abort = '0;
    sw_software_breakpoint_instruction_exec = 1'b0; permitted = 1'b1; software_breakpoint_instruction_pc = 32'h0; xfer_valid = 1'b0;
    fail_count = 0; samples_checked = 0;
    rows = '{'{10'h200, dbgec_pkg::CAUSE_HALT_REQ},
      '{10'h100, dbgec_pkg::CAUSE_HW_SOFTWARE_BREAKPOINT_INSTRUCTION}, '{10'h080, dbgec_pkg::CAUSE_IMP_WATCH},
      '{10'h040, dbgec_pkg::CAUSE_SW_SOFTWARE_BREAKPOINT_INSTRUCTION}, '{10'h020, dbgec_pkg::CAUSE_EXT_REQ},
      '{10'h010, dbgec_pkg::CAUSE_VEC_CATCH}, '{10'h008, 4'h0}, '{10'h004, 4'h0},
      '{10'h002, dbgec_pkg::CAUSE_OS_UNLOCK}, '{10'h120, 4'h4},
      '{10'h001, dbgec_pkg::CAUSE_PREC_WATCH}};
    repeat (8) @(posedge ref_clk);
    chk(sw, 32'h0);
    rstn <= 1'b1;
    foreach (rows[i]) begin
      enter(rows[i].evt);
      chk(sw, {26'h0, rows[i].cause, 2'b01});
      chk({28'h0, sw[5:2]}, {28'h0, rows[i].cause});
      chk({31'h0, halted}, 32'h1);
      dbg.leave();
      #1 chk(sw, {26'h0, rows[i].cause, 2'b00});
    end
    enter(10'h200);
    abt(3'b100);
    chk(sw & 32'hc0, 32'h40);
    xfer(1'b0);
    dbg.read_status();
    settle();
    chk(sw & 32'hc0, 32'h40);
    chk(sw_mid & 32'hc0, 32'h0);
    dbg.write_run_ctrl(32'h0000_0000);
    settle();
    chk(sw & 32'hc0, 32'h40);
    dbg.write_run_ctrl(32'h0000_0004);
    #1 chk(sw & 32'hc0, 32'h0);
    xfer(1'b1);
    abt(3'b010);
    chk(sw & 32'hc0, 32'h0);
    chk(sw_mid & 32'hc0, 32'h80);
    abt(3'b011);
    chk(sw & 32'hc0, 32'h80);
    dbg.write_run_ctrl(32'h0000_0004);
    #1 chk(sw & 32'hc0, 32'h0);
    abt(3'b010);
    dbg.leave();
    #1 t = imp_take;
    settle();
    chk({31'h0, t | imp_take}, 32'h1);
    abt(3'b100);
    chk(sw & 32'hc0, 32'h0);
    chk(sw_mid & 32'hc0, 32'h0);
    @(posedge ref_clk) begin
      permitted <= 1'b0;
      sw_software_breakpoint_instruction_exec <= 1'b1;
      software_breakpoint_instruction_pc <= 32'h1234_5678;
    end
    @(posedge ref_clk) sw_software_breakpoint_instruction_exec <= 1'b0;
    #1 chk({30'h0, dbg_exc, fault_we}, 32'h3);
    chk(fault_addr, 32'h1234_5678);
    chk({27'h0, fault_status}, {27'h0, dbgec_pkg::FAULT_DEBUG_EVENT});
    chk({28'h0, sw[5:2]}, {28'h0, dbgec_pkg::CAUSE_SW_SOFTWARE_BREAKPOINT_INSTRUCTION});
    enter(10'h100);
    chk(sw_mid & 32'hc0, 32'h80);
    @(posedge ref_clk) rstn <= 1'b0;
    #1 chk(sw, 32'h0);
    @(posedge ref_clk) rstn <= 1'b1;
    settle();
    close_out();
  end
endmodule
